// ===== dac_port_pkg.sv
package dac_port_pkg;

    // frame geometry, first bit on the wire is bit 15
    localparam int FRAME_BITS = 16;
    localparam int CNT_W      = 5;
    localparam int CODE_W     = 8;
    localparam int MODE_HI    = 13;
    localparam int MODE_LO    = 12;
    localparam int CODE_MSB   = 11;
    localparam int CODE_LSB   = 4;

    // converter register reset value: zero volts
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0]  CNT_LAST   = 5'h0f;
    localparam logic [CNT_W-1:0]  CNT_FULL   = 5'h10;

    // operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_PD_1K    = 2'b01,
        MODE_PD_100K  = 2'b10,
        MODE_PD_HIZ   = 2'b11
    } mode_e;

    // one write frame as it lands in the shift register
    typedef struct packed {
        logic [1:0]        lead_ignored;
        mode_e             mode;
        logic [CODE_W-1:0] code;
        logic [3:0]        trail_ignored;
    } frame_s;

    // analog output stage switches
    typedef struct packed {
        logic amp_on;
        logic pull_1k;
        logic pull_100k;
        logic hiz;
    } out_stage_s;

    localparam frame_s FRAME_RESET = 16'h0000;

endpackage : dac_port_pkg

// ===== dac_sync2.sv
`timescale 1ns/1ps

// two-stage synchroniser for a level into clk_sys
module dac_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : dac_sync2

// ===== dac_serial_port.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Serial bits gather in a sixteen-bit shift register, one frame.
// - Data is sampled on falling edges of the serial clock, sixteen per frame.
// - Frame select is active low and level sensitive; shift only low.
// - The sixteenth falling edge with select low executes the frame.
// - Select rising before the sixteenth edge discards the frame.
// - Code zero commands zero volts, straight binary upward.
// - Code all ones commands one step below supply; code is 8 bits.
// - Frame: two ignored, two mode, eight data, four ignored bits.
// - Mode bits: 00 normal, 01 1k down, 10 100k down, 11 three-state.
// - Reset clears the code register until the first valid normal-mode frame.
// - Power-down modes leave the stored code unchanged.
module dac_serial_port (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          sclk_link,
    input  wire logic                          frame_sel_n,
    input  wire logic                          sdata,
    output logic [dac_port_pkg::CODE_W-1:0]    dac_code_q,
    output dac_port_pkg::mode_e                mode_q,
    output dac_port_pkg::out_stage_s           out_stage_q,
    output logic                               update_q
);

    // link-domain state
    logic [dac_port_pkg::FRAME_BITS-1:0] shift_q;
    logic [dac_port_pkg::CNT_W-1:0]      bit_cnt_q;
    dac_port_pkg::frame_s                held_q;
    logic                                frame_tog_q;
    logic                                link_clr;

    // system-domain state
    logic                                frame_tog_s;
    logic                                tog_seen_q;
    logic                                frame_new;
    dac_port_pkg::frame_s                frame_in;

    // output stage switches for a mode
    function automatic dac_port_pkg::out_stage_s stage_of(
        input dac_port_pkg::mode_e m
    );
        dac_port_pkg::out_stage_s s;
        s = '0;
        case (m)
            dac_port_pkg::MODE_NORMAL:  s.amp_on    = 1'b1;
            dac_port_pkg::MODE_PD_1K:   s.pull_1k   = 1'b1;
            dac_port_pkg::MODE_PD_100K: s.pull_100k = 1'b1;
            dac_port_pkg::MODE_PD_HIZ:  s.hiz       = 1'b1;
            default:                    s.hiz       = 1'b1;
        endcase
        return s;
    endfunction : stage_of

    // link clear: select high drops a partial frame, reset clears at start
    assign link_clr = frame_sel_n | reset;

    // shift on falling edges while select low; clear drops partial frame
    always_ff @(negedge sclk_link or posedge link_clr)
    begin
        if (link_clr)
        begin
            shift_q   <= '0;
            bit_cnt_q <= dac_port_pkg::CNT_ZERO;
        end
        else if (bit_cnt_q != dac_port_pkg::CNT_FULL)
        begin
            shift_q   <= {shift_q[dac_port_pkg::FRAME_BITS-2:0], sdata};
            bit_cnt_q <= bit_cnt_q + dac_port_pkg::CNT_ONE;
        end
    end

    // sixteenth edge: capture whole frame and flag it across domains
    always_ff @(negedge sclk_link or posedge reset)
    begin
        if (reset)
        begin
            held_q      <= dac_port_pkg::FRAME_RESET;
            frame_tog_q <= 1'b0;
        end
        else if (!frame_sel_n &&
                 bit_cnt_q == dac_port_pkg::CNT_LAST)
        begin
            held_q      <= {shift_q[dac_port_pkg::FRAME_BITS-2:0],
                            sdata};
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // frame toggle into clk_sys
    dac_sync2 #(
        .WIDTH    (1)
    ) u_tog_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (frame_tog_q),
        .sync_out (frame_tog_s)
    );

    // held frame is stable for many system cycles after the toggle
    assign frame_new = frame_tog_s ^ tog_seen_q;
    assign frame_in  = held_q;

    // toggle edge detector
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tog_seen_q <= 1'b0;
        else
            tog_seen_q <= frame_tog_s;
    end

    // converter register, loaded only from a normal-mode frame
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            dac_code_q <= dac_port_pkg::CODE_RESET;
        else if (frame_new &&
                 frame_in.mode == dac_port_pkg::MODE_NORMAL)
            dac_code_q <= frame_in.code;
    end

    // operating mode and output stage
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mode_q      <= dac_port_pkg::MODE_NORMAL;
            out_stage_q <= stage_of(dac_port_pkg::MODE_NORMAL);
        end
        else if (frame_new)
        begin
            mode_q      <= frame_in.mode;
            out_stage_q <= stage_of(frame_in.mode);
        end
    end

    // one-cycle pulse per executed frame
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            update_q <= 1'b0;
        else
            update_q <= frame_new;
    end

endmodule : dac_serial_port

// ===== dac_port_properties.sv
`timescale 1ns/1ps
module dac_port_properties (
    input wire logic                        clk_sys,
    input wire logic                        reset,
    input wire logic                        sclk_link,
    input wire logic                        frame_sel_n,
    input wire logic                        sdata,
    input wire logic [dac_port_pkg::CODE_W-1:0] dac_code_q,
    input wire dac_port_pkg::mode_e         mode_q,
    input wire dac_port_pkg::out_stage_s    out_stage_q,
    input wire logic                        update_q
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // reset state and output relations
    a_reset_clears_code: assert property (disable iff (1'b0)
        reset |=> dac_code_q == 8'h00 && !update_q) else $error("code not 0");
    a_reset_mode_normal: assert property (disable iff (1'b0)
        reset |=> mode_q == dac_port_pkg::MODE_NORMAL) else $error("mode");
    a_update_one_cycle: assert property (update_q |=> !update_q)
        else $error("update pulse too long");
    // code, mode and update pulse all load on the same edge
    a_code_change_flag: assert property (
        $changed(dac_code_q) |-> update_q)
        else $error("code moved without update");
    a_mode_change_flag: assert property (
        $changed(mode_q) |-> update_q)
        else $error("mode moved without update");
    a_stage_one_hot: assert property ($onehot(out_stage_q))
        else $error("output stage not one-hot");
    a_stage_from_mode: assert property (
        out_stage_q == {mode_q == 2'b00, mode_q == 2'b01,
        mode_q == 2'b10, mode_q == 2'b11}) else $error("stage");
    a_powerdown_keeps_code: assert property (
        $rose(update_q) && mode_q != 2'b00
        |-> dac_code_q == $past(dac_code_q, 2)) else $error("code lost");
endmodule : dac_port_properties
bind dac_serial_port dac_port_properties u_chk (.clk_sys, .reset, .sclk_link,
    .frame_sel_n, .sdata, .dac_code_q, .mode_q, .out_stage_q, .update_q);

// ===== host_model.sv
`timescale 1ns/1ps
module host_model (
    output logic sclk_link,
    output logic frame_sel_n,
    output logic sdata
);
    initial
    begin
        // idle levels land after every process waits on its edges
        sclk_link <= 1'b0;
        frame_sel_n <= 1'b1;
        sdata <= 1'b0;
    end
    // one burst of n edges, clock still outside it
    task send(input logic [31:0] d, input int n);
        frame_sel_n = 1'b0;
        #10;
        for (int i = 0; i < n; i++)
        begin
            sclk_link = 1'b1;
            sdata = d[31-i];
            #3;
            sclk_link = 1'b0;
            #3;
        end
        sdata = ~sdata; // released line shows no stale bit
        frame_sel_n = 1'b1;
        #40;
    endtask : send
endmodule : host_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b0;
    logic sclk_link, frame_sel_n, sdata, update_q;
    logic [7:0] dac_code_q;
    dac_port_pkg::mode_e mode_q;
    dac_port_pkg::out_stage_s out_stage_q;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int got = 0;
    // frame, expected code, expected mode
    logic [25:0] rows [6] = '{{16'h0ff0, 10'h3fc}, {16'h1a50, 10'h3fd},
        {16'h2000, 10'h3fe}, {16'hf3c3, 10'h3ff}, {16'h0000, 10'h000},
        {16'hc7ef, 10'h1f8}};
    always #10 clk_sys = ~clk_sys;
    host_model u_host (.sclk_link, .frame_sel_n, .sdata);
    dac_serial_port u_dut (.clk_sys, .reset, .sclk_link, .frame_sel_n,
        .sdata, .dac_code_q, .mode_q, .out_stage_q, .update_q);
    task check(logic [9:0] seen, logic [9:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t output mismatch", $time);
        end
    endtask : check
    // send a burst and watch for the update pulse
    task frame(logic [31:0] d, int n);
        got = 0;
        fork
            u_host.send(d, n);
            repeat (20) @(negedge clk_sys) if (update_q === 1'b1) got++;
        join
    endtask : frame
    task stop_test;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        reset <= 1'b1; // edge at time zero, after processes start, so async clears see it
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check({dac_code_q, mode_q}, 10'h000);
        foreach (rows[i])
        begin
            frame({rows[i][25:10], 16'h0000}, 16);
            check(10'(got), 10'h001);
            check({dac_code_q, mode_q}, rows[i][9:0]);
            check(10'(out_stage_q), 10'(4'h8 >> rows[i][1:0]));
        end
        frame(32'h05500000, 15);
        check(10'(got), 10'h000);
        check({dac_code_q, mode_q}, 10'h1f8);
        // second half is a valid frame that a wrapping counter would run
        frame(32'h01200ff0, 32);
        check(10'(got), 10'h001);
        check({dac_code_q, mode_q}, 10'h048);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check({dac_code_q, mode_q}, 10'h000);
        // link path recovers after a mid-run reset
        frame(32'h05500000, 16);
        check(10'(got), 10'h001);
        check({dac_code_q, mode_q}, 10'h154);
        stop_test();
    end
endmodule : testbench
